/* File: common/ssp_consts.svh */
// Constants for the synchronous serial port: widths, depths, counts.
// Assumes inclusion by bare name from the package and design files.
`ifndef SSP_CONSTS_SVH
`define SSP_CONSTS_SVH

`define SSP_WORD_W 16
`define SSP_FIFO_DEPTH 8
`define SSP_PTR_W 3
`define SSP_CNT_W 4
`define SSP_CMD_BITS 5'h08
`define SSP_CMD_TOP 4'h7
`define SSP_BITCNT_W 5
`define SSP_MIN_SIZE_M1 4'h3

`endif

/* File: common/ssp_pkg.sv */
// Types for the synchronous serial port.
// Assumes ssp_consts.svh is on the include path.
`include "ssp_consts.svh"

package ssp_pkg;

  // Engine states, Gray coded along idle, run, done
  typedef enum logic [1:0] {
    SSP_IDLE = 2'h0,
    SSP_RUN = 2'h1,
    SSP_DONE = 2'h3
  } ssp_state_t;

  // Frame formats
  typedef enum logic [1:0] {
    SSP_FMT_SPI = 2'h0,
    SSP_FMT_PULSE = 2'h1,
    SSP_FMT_CMD = 2'h2
  } ssp_fmt_t;

endpackage

/* File: hdl/ssp_fifo.sv */
// Eight-word, sixteen-bit flip-flop queue with count.
// Assumes push is never given when full nor pop when empty.
`timescale 1ns/1ps
`include "ssp_consts.svh"

module ssp_fifo (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  // Write side
  input wire logic push_in,
  input wire logic [`SSP_WORD_W-1:0] data_in,
  // Read side
  input wire logic pop_in,
  output logic [`SSP_WORD_W-1:0] head_out,
  output logic [`SSP_CNT_W-1:0] count_out
);

  logic [`SSP_WORD_W-1:0] mem [`SSP_FIFO_DEPTH];
  logic [`SSP_WORD_W-1:0] next_mem [`SSP_FIFO_DEPTH];
  logic [`SSP_PTR_W-1:0] wr_ptr;
  logic [`SSP_PTR_W-1:0] next_wr_ptr;
  logic [`SSP_PTR_W-1:0] rd_ptr;
  logic [`SSP_PTR_W-1:0] next_rd_ptr;
  logic [`SSP_CNT_W-1:0] count;
  logic [`SSP_CNT_W-1:0] next_count;

  assign head_out = mem[rd_ptr];
  assign count_out = count;

  always_comb begin
    next_mem = mem;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    if (push_in) begin
      next_mem[wr_ptr] = data_in;
      next_wr_ptr = wr_ptr + 3'h1;
    end
    if (pop_in) begin
      next_rd_ptr = rd_ptr + 3'h1;
    end
    if (push_in && !pop_in) begin
      next_count = count + 4'h1;
    end else if (pop_in && !push_in) begin
      next_count = count - 4'h1;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < `SSP_FIFO_DEPTH; i++) begin
        mem[i] <= 16'h0000;
      end
      wr_ptr <= 3'h0;
      rd_ptr <= 3'h0;
      count <= 4'h0;
    end else if (ce_in) begin
      mem <= next_mem;
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

endmodule

/* File: hdl/ssp_top.sv */
// Synchronous serial port: queues, frame engine, clock divider.
// Assumes link pins are synchronous to clock_in; pads resolve enables.
// Summary of operation
// - Serial bits in become words; queued words go out serially.
// - Link has clock, frame, transmit data and receive data wires.
// - Three selectable frame formats: SPI, pulse frame, command frame.
// - Frame length programmable from 4 to 16 bits; the command frame adds 8 command bits ahead of them.
// - Separate independent eight-word sixteen-bit transmit and receive queues.
// - Master drives clock and frame; slave accepts them from outside.
// - Slave may be told not to drive its data output.
// - Master clock comes from a prescaler then a rate divider.
// - Loopback feeds transmit data back to receive internally.
`timescale 1ns/1ps
`include "ssp_consts.svh"

module ssp_top (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  // Configuration
  input wire logic enable_in,
  input wire logic master_in,
  input wire logic [1:0] fmt_in,
  input wire logic [3:0] size_m1_in,
  input wire logic [7:0] prescale_in,
  input wire logic [7:0] rate_in,
  input wire logic slave_out_dis_in,
  input wire logic loopback_in,
  // Transmit queue
  input wire logic tx_write_in,
  input wire logic [`SSP_WORD_W-1:0] tx_data_in,
  // Receive queue
  input wire logic rx_read_in,
  output logic [`SSP_WORD_W-1:0] rx_data_out,
  // Status
  output logic tx_empty_out,
  output logic tx_not_full_out,
  output logic rx_not_empty_out,
  output logic rx_full_out,
  output logic busy_out,
  // Link pins
  input wire logic sclk_in,
  output logic sclk_out,
  output logic sclk_oe_n_out,
  input wire logic fss_in,
  output logic fss_out,
  output logic fss_oe_n_out,
  input wire logic rxd_in,
  output logic txd_out,
  output logic txd_oe_n_out
);

  // ****************************************
  // Queues
  // ****************************************
  logic [`SSP_WORD_W-1:0] tx_head;
  logic [`SSP_CNT_W-1:0] tx_count;
  logic [`SSP_WORD_W-1:0] rx_head;
  logic [`SSP_CNT_W-1:0] rx_count;
  logic tx_push;
  logic tx_pop;
  logic rx_push;
  logic rx_pop;
  logic [`SSP_WORD_W-1:0] rx_word;
  logic tx_full;
  logic rx_full;

  assign tx_full = tx_count == 4'h8;
  assign rx_full = rx_count == 4'h8;
  assign tx_push = tx_write_in && !tx_full;
  assign rx_pop = rx_read_in && rx_count != 4'h0;

  ssp_fifo u_tx_fifo (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .push_in(tx_push),
    .data_in(tx_data_in),
    .pop_in(tx_pop),
    .head_out(tx_head),
    .count_out(tx_count)
  );

  ssp_fifo u_rx_fifo (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .push_in(rx_push),
    .data_in(rx_word),
    .pop_in(rx_pop),
    .head_out(rx_head),
    .count_out(rx_count)
  );

  // ****************************************
  // Frame engine
  // ****************************************
  ssp_pkg::ssp_state_t state;
  ssp_pkg::ssp_state_t next_state;
  logic [`SSP_BITCNT_W-1:0] cnt;
  logic [`SSP_BITCNT_W-1:0] next_cnt;
  logic [`SSP_WORD_W-1:0] tx_shift;
  logic [`SSP_WORD_W-1:0] next_tx_shift;
  logic [`SSP_WORD_W-1:0] rx_shift;
  logic [`SSP_WORD_W-1:0] next_rx_shift;
  logic [7:0] pre_cnt;
  logic [7:0] next_pre_cnt;
  logic [7:0] rate_cnt;
  logic [7:0] next_rate_cnt;
  logic sclk_r;
  logic next_sclk_r;
  logic fss_r;
  logic next_fss_r;
  logic next_txd_r;
  logic sclk_q;
  logic fss_q;
  logic is_cmd;
  logic is_pulse;
  logic [`SSP_BITCNT_W-1:0] nbits;
  logic [3:0] top;
  logic tx_bit;
  logic rx_bit;
  logic pre_done;
  logic half;
  logic rise;
  logic fall;
  logic sample;
  logic shift;
  logic start;
  logic abort;
  logic fss_idle;
  logic [`SSP_WORD_W-1:0] size_mask;

  always_comb begin
    is_cmd = fmt_in == ssp_pkg::SSP_FMT_CMD;
    is_pulse = fmt_in == ssp_pkg::SSP_FMT_PULSE;
    fss_idle = !is_pulse;
    // Sizes below four bits are raised to four
    top = (size_m1_in < `SSP_MIN_SIZE_M1) ? `SSP_MIN_SIZE_M1 : size_m1_in;
    size_mask = 16'hffff >> (4'hf - top);
    nbits = {1'b0, top} + 5'h01 + (is_cmd ? `SSP_CMD_BITS : 5'h00);
    tx_bit = tx_shift[is_cmd ? `SSP_CMD_TOP : top];
    rx_bit = loopback_in ? tx_bit : rxd_in;
    pre_done = {1'b0, pre_cnt} + 9'h001 >= {1'b0, prescale_in};
    half = state == ssp_pkg::SSP_RUN && pre_done && rate_cnt >= rate_in;
    if (master_in) begin
      rise = half && !sclk_r;
      fall = half && sclk_r;
      start = tx_count != 4'h0;
      abort = 1'b0;
    end else begin
      rise = state == ssp_pkg::SSP_RUN && sclk_in && !sclk_q;
      fall = state == ssp_pkg::SSP_RUN && !sclk_in && sclk_q;
      start = is_pulse ? (fss_in && !fss_q) : (!fss_in && fss_q);
      abort = !is_pulse && fss_in && state == ssp_pkg::SSP_RUN;
    end
    sample = is_pulse ? fall : rise;
    shift = (is_pulse ? rise : fall) && cnt != 5'h00;
  end

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_tx_shift = tx_shift;
    next_rx_shift = rx_shift;
    next_pre_cnt = 8'h00;
    next_rate_cnt = 8'h00;
    next_sclk_r = sclk_r;
    next_fss_r = fss_r;
    tx_pop = 1'b0;
    rx_push = 1'b0;
    rx_word = rx_shift & size_mask;
    case (state)
      ssp_pkg::SSP_IDLE: begin
        next_sclk_r = 1'b0;
        next_fss_r = fss_idle;
        next_cnt = 5'h00;
        if (enable_in && start) begin
          tx_pop = tx_count != 4'h0;
          next_tx_shift = tx_pop ? tx_head : 16'h0000;
          next_fss_r = !fss_idle;
          next_state = ssp_pkg::SSP_RUN;
        end
      end
      ssp_pkg::SSP_RUN: begin
        // Half bit period is prescale times (rate plus one) cycles, a prescale of zero counting as one
        next_pre_cnt = pre_done ? 8'h00 : pre_cnt + 8'h01;
        next_rate_cnt = rate_cnt;
        if (pre_done) begin
          next_rate_cnt = half ? 8'h00 : rate_cnt + 8'h01;
        end
        if (half) begin
          next_sclk_r = !sclk_r;
        end
        if (shift) begin
          next_tx_shift = {tx_shift[14:0], 1'b0};
        end
        if (sample) begin
          next_cnt = cnt + 5'h01;
          if (!is_cmd || cnt >= `SSP_CMD_BITS) begin
            next_rx_shift = {rx_shift[14:0], rx_bit};
          end
        end
        if (is_pulse && fall) begin
          next_fss_r = 1'b0;
        end
        if (fall && next_cnt == nbits) begin
          next_state = ssp_pkg::SSP_DONE;
        end
        if (abort || !enable_in) begin
          next_state = ssp_pkg::SSP_IDLE;
        end
      end
      ssp_pkg::SSP_DONE: begin
        rx_push = !rx_full;
        next_rx_shift = 16'h0000;
        next_fss_r = fss_idle;
        next_sclk_r = 1'b0;
        next_state = ssp_pkg::SSP_IDLE;
      end
      default: begin
        next_state = ssp_pkg::SSP_IDLE;
      end
    endcase
    next_txd_r = next_tx_shift[is_cmd ? `SSP_CMD_TOP : top];
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= ssp_pkg::SSP_IDLE;
      cnt <= 5'h00;
      tx_shift <= 16'h0000;
      rx_shift <= 16'h0000;
      pre_cnt <= 8'h00;
      rate_cnt <= 8'h00;
      sclk_r <= 1'b0;
      fss_r <= 1'b1;
      sclk_q <= 1'b0;
      fss_q <= 1'b1;
    end else if (ce_in) begin
      state <= next_state;
      cnt <= next_cnt;
      tx_shift <= next_tx_shift;
      rx_shift <= next_rx_shift;
      pre_cnt <= next_pre_cnt;
      rate_cnt <= next_rate_cnt;
      sclk_r <= next_sclk_r;
      fss_r <= next_fss_r;
      sclk_q <= sclk_in;
      fss_q <= fss_in;
    end
  end

  // ****************************************
  // Registered outputs
  // ****************************************
  logic next_sclk_oe_n;
  logic next_txd_oe_n;
  logic drive_link;

  always_comb begin
    drive_link = enable_in && master_in;
    next_sclk_oe_n = !drive_link;
    next_txd_oe_n = !(enable_in && (master_in || !slave_out_dis_in));
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sclk_out <= 1'b0;
      sclk_oe_n_out <= 1'b1;
      fss_out <= 1'b1;
      fss_oe_n_out <= 1'b1;
      txd_out <= 1'b0;
      txd_oe_n_out <= 1'b1;
      rx_data_out <= 16'h0000;
      tx_empty_out <= 1'b1;
      tx_not_full_out <= 1'b1;
      rx_not_empty_out <= 1'b0;
      rx_full_out <= 1'b0;
      busy_out <= 1'b0;
    end else if (ce_in) begin
      sclk_out <= next_sclk_r;
      sclk_oe_n_out <= next_sclk_oe_n;
      fss_out <= next_fss_r;
      fss_oe_n_out <= next_sclk_oe_n;
      txd_out <= next_txd_r;
      txd_oe_n_out <= next_txd_oe_n;
      rx_data_out <= rx_head;
      tx_empty_out <= tx_count == 4'h0;
      tx_not_full_out <= !tx_full;
      rx_not_empty_out <= rx_count != 4'h0;
      rx_full_out <= rx_full;
      busy_out <= next_state != ssp_pkg::SSP_IDLE;
    end
  end

endmodule

/* File: sim/ssp_top_assertions.sv */
// Checker for the serial port top: link pins and status flags.
// Assumes binding to ssp_top and one clock domain.
`timescale 1ns/1ps
module ssp_chk (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // Control
  input wire logic ce_in,
  input wire logic enable_in,
  input wire logic master_in,
  input wire logic [1:0] fmt_in,
  input wire logic [3:0] size_m1_in,
  input wire logic [7:0] prescale_in,
  input wire logic [7:0] rate_in,
  input wire logic slave_out_dis_in,
  input wire logic tx_write_in,
  // Status and pins
  input wire logic tx_empty_out,
  input wire logic tx_not_full_out,
  input wire logic rx_not_empty_out,
  input wire logic rx_full_out,
  input wire logic busy_out,
  input wire logic sclk_out,
  input wire logic sclk_oe_n_out,
  input wire logic fss_out,
  input wire logic fss_oe_n_out,
  input wire logic txd_oe_n_out
);
  // ****************
  // Helper counters
  // ****************
  int run, rises, h;
  logic sclk_q, fss_q;
  assign h = (prescale_in > 8'h01 ? int'(prescale_in) : 1) *
    (int'(rate_in) + 1);
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      run <= 0;
      rises <= 0;
      sclk_q <= 1'b0;
      fss_q <= 1'b1;
    end else begin
      sclk_q <= sclk_out;
      fss_q <= fss_out;
      run <= (sclk_out != sclk_q) ? 1 : run + 1;
      if (!fss_out && fss_q) begin
        rises <= 0;
      end else if (sclk_out && !sclk_q) begin
        rises <= rises + 1;
      end
    end
  end
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_push;
    ce_in && tx_write_in && tx_empty_out;
  endsequence
  sequence s_start;
    s_push ##0 (master_in && enable_in && !busy_out);
  endsequence
  // ****************
  // Assertions
  // ****************
  tx_flags_a:
    assert property (tx_empty_out |-> tx_not_full_out) else $error("tx flags");
  rx_flags_a:
    assert property (rx_full_out |-> rx_not_empty_out) else $error("rx flags");
  master_drive_a:
    assert property ((master_in && enable_in)[*2] |->
      !sclk_oe_n_out && !fss_oe_n_out) else $error("master not driving");
  slave_listen_a:
    assert property ((!master_in)[*2] |-> sclk_oe_n_out && fss_oe_n_out)
    else $error("slave drives clock");
  slave_quiet_a:
    assert property ((!master_in && slave_out_dis_in)[*2] |-> txd_oe_n_out)
    else $error("slave drives data");
  sclk_rate_a:
    assert property (master_in && !sclk_oe_n_out && sclk_out != sclk_q
      |-> run >= h) else $error("clock level too short");
  frame_bits_a:
    assert property ($rose(fss_out) && master_in && fmt_in == 2'h0 &&
      enable_in |-> rises == int'(size_m1_in) + 1) else $error("bit count");
  idle_low_a:
    assert property (master_in && !fss_oe_n_out && fmt_in == 2'h0 && fss_out
      |-> !sclk_out) else $error("clock not idle low");
  push_seen_a:
    assert property (s_push |-> ##2 !tx_empty_out) else $error("push lost");
  start_busy_a:
    assert property (s_start |-> ##2 busy_out) else $error("no start");
endmodule
bind ssp_top ssp_chk chk (
  .clock_in(clock_in),
  .rst_n_in(rst_n_in),
  .ce_in(ce_in),
  .enable_in(enable_in),
  .master_in(master_in),
  .fmt_in(fmt_in),
  .size_m1_in(size_m1_in),
  .prescale_in(prescale_in),
  .rate_in(rate_in),
  .slave_out_dis_in(slave_out_dis_in),
  .tx_write_in(tx_write_in),
  .tx_empty_out(tx_empty_out),
  .tx_not_full_out(tx_not_full_out),
  .rx_not_empty_out(rx_not_empty_out),
  .rx_full_out(rx_full_out),
  .busy_out(busy_out),
  .sclk_out(sclk_out),
  .sclk_oe_n_out(sclk_oe_n_out),
  .fss_out(fss_out),
  .fss_oe_n_out(fss_oe_n_out),
  .txd_oe_n_out(txd_oe_n_out)
);

/* File: sim/ssp_peer.sv */
// Peer device on the serial link, clock idle low, MSB first.
// Assumes it sees the port's pins as a selected slave.
`timescale 1ns/1ps
module ssp_peer (
  // Link pins
  input wire logic sclk_in,
  input wire logic fss_in,
  input wire logic txd_in,
  output logic rxd_out,
  // Frame setup and result
  input wire logic [3:0] size_m1_in,
  input wire logic [15:0] word_in,
  output logic [15:0] got_out
);
  int idx;
  initial begin
    rxd_out = 1'b0;
    got_out = 16'h0000;
    idx = 0;
  end
  always @(negedge fss_in) begin
    idx = size_m1_in;
    got_out = 16'h0000;
    rxd_out = word_in[idx];
  end
  always @(posedge fss_in) rxd_out = ~rxd_out;
  always @(posedge sclk_in) begin
    if (!fss_in) got_out = {got_out[14:0], txd_in};
  end
  always @(negedge sclk_in) begin
    if (!fss_in && idx > 0) begin
      idx = idx - 1;
      rxd_out = word_in[idx];
    end
  end
endmodule

/* File: sim/tb.sv */
// Self-checking bench for the serial port top.
// Assumes ssp_top, ssp_peer and the checker are compiled.
`timescale 1ns/1ps
module tb;
  logic clock_in, rst_n_in, ce_in, enable_in, master_in, slave_out_dis_in;
  logic loopback_in, tx_write_in, rx_read_in, sclk_in, fss_in, rxd_in;
  logic [1:0] fmt_in;
  logic [3:0] size_m1_in;
  logic [7:0] prescale_in, rate_in;
  logic [15:0] tx_data_in, rx_data_out, pword, got, m;
  logic tx_empty_out, tx_not_full_out, rx_not_empty_out, rx_full_out;
  logic busy_out, sclk_out, sclk_oe_n_out, fss_out, fss_oe_n_out;
  logic txd_out, txd_oe_n_out;
  int mismatches, checked;
  ssp_top dut (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .enable_in(enable_in),
    .master_in(master_in),
    .fmt_in(fmt_in),
    .size_m1_in(size_m1_in),
    .prescale_in(prescale_in),
    .rate_in(rate_in),
    .slave_out_dis_in(slave_out_dis_in),
    .loopback_in(loopback_in),
    .tx_write_in(tx_write_in),
    .tx_data_in(tx_data_in),
    .rx_read_in(rx_read_in),
    .rx_data_out(rx_data_out),
    .tx_empty_out(tx_empty_out),
    .tx_not_full_out(tx_not_full_out),
    .rx_not_empty_out(rx_not_empty_out),
    .rx_full_out(rx_full_out),
    .busy_out(busy_out),
    .sclk_in(sclk_in),
    .sclk_out(sclk_out),
    .sclk_oe_n_out(sclk_oe_n_out),
    .fss_in(fss_in),
    .fss_out(fss_out),
    .fss_oe_n_out(fss_oe_n_out),
    .rxd_in(rxd_in),
    .txd_out(txd_out),
    .txd_oe_n_out(txd_oe_n_out)
  );
  ssp_peer peer (.sclk_in(sclk_out), .fss_in(fss_out), .txd_in(txd_out),
    .rxd_out(rxd_in), .size_m1_in(size_m1_in), .word_in(pword),
    .got_out(got));
  initial begin
    clock_in = 1'b0;
    forever #12.5 clock_in = ~clock_in;
  end
  // ****************
  // Tasks
  // ****************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic put(input logic [15:0] w);
    tx_data_in <= w;
    tx_write_in <= 1'b1;
    @(posedge clock_in);
    tx_write_in <= 1'b0;
    @(posedge clock_in);
  endtask
  task automatic take(input logic [15:0] exp);
    check(rx_data_out, exp);
    rx_read_in <= 1'b1;
    @(posedge clock_in);
    rx_read_in <= 1'b0;
    repeat (3) @(posedge clock_in);
  endtask
  task automatic settle();
    int n;
    n = 0;
    repeat (3) @(posedge clock_in);
    while ((busy_out !== 1'b0 || tx_empty_out !== 1'b1) && n < 4000) begin
      @(posedge clock_in);
      n++;
    end
    if (n >= 4000) begin
      mismatches++;
    end
    repeat (4) @(posedge clock_in);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clock_in);
    mismatches++;
    final_report();
  end
  // ****************
  // Tests
  // ****************
  initial begin
    {ce_in, enable_in, master_in, slave_out_dis_in, loopback_in} = 5'h10;
    {tx_write_in, rx_read_in, sclk_in, fss_in, rst_n_in} = 5'h02;
    fmt_in = 2'h0;
    size_m1_in = 4'hf;
    prescale_in = 8'h02;
    rate_in = 8'h01;
    tx_data_in = 16'h0000;
    pword = 16'hc3a5;
    repeat (10) @(posedge clock_in);
    check({tx_empty_out, tx_not_full_out, rx_not_empty_out, rx_full_out,
      busy_out}, 16'h0018);
    check({sclk_oe_n_out, fss_oe_n_out, txd_oe_n_out}, 16'h0007);
    rst_n_in <= 1'b1;
    master_in <= 1'b1;
    enable_in <= 1'b1;
    $display("test reset done");
    for (int s = 3; s < 16; s++) begin
      size_m1_in <= s[3:0];
      m = 16'hffff >> (15 - s);
      @(posedge clock_in);
      put(16'h96e1);
      settle();
      check(got, 16'h96e1 & m);
      take(16'hc3a5 & m);
    end
    $display("test sizes done");
    {loopback_in, prescale_in, rate_in, size_m1_in} <= 21'h1_0100_b;
    for (int f = 0; f < 3; f++) begin
      fmt_in <= f[1:0];
      @(posedge clock_in);
      put(16'h0a5f);
      settle();
      take(f == 2 ? 16'h0000 : 16'h0a5f);
    end
    $display("test formats done");
    fmt_in <= 2'h0;
    enable_in <= 1'b0;
    @(posedge clock_in);
    ce_in <= 1'b0;
    put(16'h0777);
    ce_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    check(tx_empty_out, 16'h0001);
    for (int i = 0; i < 9; i++) put(16'h0100 + i);
    check(tx_not_full_out, 16'h0000);
    enable_in <= 1'b1;
    settle();
    check(rx_full_out, 16'h0001);
    put(16'h0eee);
    settle();
    for (int i = 0; i < 8; i++) take(16'h0100 + i);
    check(rx_not_empty_out, 16'h0000);
    $display("test queues done");
    master_in <= 1'b0;
    slave_out_dis_in <= 1'b1;
    repeat (3) @(posedge clock_in);
    check({sclk_oe_n_out, fss_oe_n_out, txd_oe_n_out}, 16'h0007);
    slave_out_dis_in <= 1'b0;
    put(16'h0c3c);
    check(txd_oe_n_out, 16'h0000);
    fss_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    repeat (12) begin
      sclk_in <= 1'b1;
      repeat (2) @(posedge clock_in);
      sclk_in <= 1'b0;
      repeat (2) @(posedge clock_in);
    end
    repeat (2) @(posedge clock_in);
    fss_in <= 1'b1;
    repeat (4) @(posedge clock_in);
    take(16'h0c3c);
    $display("test slave done");
    final_report();
  end
endmodule
